// *** logic/ood_params.svh ***
// timing and code constants for the one-of-eight decoder host controller
`ifndef OOD_PARAMS_SVH
`define OOD_PARAMS_SVH
`define OOD_CLK_PERIOD_NS 50
`define OOD_DEC_DELAY_NS 18
`define OOD_SETTLE_CYC ((`OOD_DEC_DELAY_NS + `OOD_CLK_PERIOD_NS - 1) / `OOD_CLK_PERIOD_NS)
`define OOD_ST_FIRST 3'h2
`define OOD_ST_FIRST_INT 3'h6
`define OOD_ST_SECOND 3'h4
`define OOD_ST_WAIT 3'h0
`define OOD_ST_THIRD 3'h1
`define OOD_ST_STOP 3'h3
`define OOD_ST_FOURTH 3'h7
`define OOD_ST_FIFTH 3'h5
`define OOD_NUM_DEC 3
`define OOD_ADDR_W 5
`endif

// *** logic/ood_pkg.sv ***
// types for the one-of-eight decoder host controller
package ood_pkg;
	typedef enum logic [1:0] {
		OOD_IDLE,
		OOD_DRIVE,
		OOD_SAMPLE
	} ood_seq_t;
endpackage

// *** logic/ood_sync.sv ***
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/100ps
module ood_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// data
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta <= '1;
			q_out <= '1;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule // ood_sync

// *** logic/ood_host.sv ***
// host controller that drives a cascaded one-of-eight decoder array and reads its selects
//
// Overview of operation
// - one decoder output may enable each of up to eight downstream decoders.
// - three decoders on five weighted address lines give 24 exclusive selects.
// - upper address bits pick the chip select; lower bits go to every device.
// - state lines feed selects; second clock phase and sync feed the enables.
// - system reset gates an enable so no strobe appears during reset.
// - state codes map to the eight machine states as tabled.
`timescale 1ns/100ps
`include "ood_params.svh"
module ood_host #(
	parameter int NUM_DEC = `OOD_NUM_DEC,
	parameter int ADDR_W = `OOD_ADDR_W,
	parameter int SETTLE_CYC = `OOD_SETTLE_CYC
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// user request: decode an address
	input wire logic req_in,
	input wire logic [ADDR_W-1:0] addr_in,
	output logic busy_out,
	output logic done_out,
	output logic [NUM_DEC*8-1:0] selects_n_out,
	output logic exclusive_ok_out,
	// user request: machine-state strobe
	input wire logic [2:0] cpu_state_in,
	input wire logic phase2_in,
	input wire logic sync_n_in,
	input wire logic sys_reset_in,
	// pins to each decoder of the array
	output logic select_bit_weight1_out,
	output logic select_bit_weight2_out,
	output logic select_bit_weight4_out,
	output logic [NUM_DEC-1:0] enable_low_first_out,
	output logic [NUM_DEC-1:0] enable_low_second_out,
	output logic [NUM_DEC-1:0] enable_high_third_out,
	input wire logic [NUM_DEC*8-1:0] decoded_out_n_in,
	// state decoder pins
	output logic cpu_state_line_first_out,
	output logic cpu_state_line_second_out,
	output logic cpu_state_line_third_out,
	output logic strobe_phase2_out,
	output logic strobe_sync_n_out,
	output logic strobe_reset_n_out,
	input wire logic [7:0] state_strobe_n_in,
	output logic first_state_strobe_out,
	output logic [7:0] state_strobes_out
);
	localparam int SW = (SETTLE_CYC < 2) ? 2 : $clog2(SETTLE_CYC + 1) + 1;

	ood_pkg::ood_seq_t seq;
	logic [SW-1:0] wait_cnt;
	logic [ADDR_W-1:0] addr_q;
	logic [NUM_DEC*8-1:0] sel_sync;
	logic [7:0] strobe_sync;
	logic [ADDR_W-4:0] bank;
	logic [NUM_DEC*8-1:0] expect_n;
	logic [NUM_DEC*8-1:0] next_expect_n;

	// decoder outputs come from asynchronous logic; only read after the settle wait
	ood_sync #(.WIDTH(NUM_DEC*8)) u_sel_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.d_in(decoded_out_n_in),
		.q_out(sel_sync)
	);

	// strobes are synchronised as one word, so a code change lands in a single cycle
	ood_sync #(.WIDTH(8)) u_strobe_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.d_in(state_strobe_n_in),
		.q_out(strobe_sync)
	);

	assign bank = addr_q[ADDR_W-1:3];

	// predicted decoder array answer for the latched address
	always_comb begin
		next_expect_n = '1;
		for (int i = 0; i < NUM_DEC*8; i++) begin
			if (i[ADDR_W-1:0] == addr_q) begin
				next_expect_n[i] = 1'b0;
			end
		end
	end
	assign expect_n = next_expect_n;

	// request sequencer: drive pins, wait settle plus synchroniser, then sample
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			seq <= ood_pkg::OOD_IDLE;
			wait_cnt <= '0;
			addr_q <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			unique case (seq)
				ood_pkg::OOD_IDLE: begin
					if (req_in) begin
						addr_q <= addr_in;
						busy_out <= 1'b1;
						wait_cnt <= '0;
						seq <= ood_pkg::OOD_DRIVE;
					end
				end
				ood_pkg::OOD_DRIVE: begin
					// settle time plus two synchroniser stages
					if (wait_cnt == SW'(SETTLE_CYC + 2)) begin
						seq <= ood_pkg::OOD_SAMPLE;
					end else begin
						wait_cnt <= wait_cnt + SW'(1);
					end
				end
				ood_pkg::OOD_SAMPLE: begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					seq <= ood_pkg::OOD_IDLE;
				end
				// the fourth code of the state register is unused; fall back to idle
				default: begin
					busy_out <= 1'b0;
					seq <= ood_pkg::OOD_IDLE;
				end
			endcase
		end
	end

	// address pins: low bits go to every decoder of the array
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			select_bit_weight1_out <= 1'b0;
			select_bit_weight2_out <= 1'b0;
			select_bit_weight4_out <= 1'b0;
		end else begin
			select_bit_weight1_out <= addr_q[0];
			select_bit_weight2_out <= addr_q[1];
			select_bit_weight4_out <= addr_q[2];
		end
	end

	// enables: upper bits choose the one decoder that may answer
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			enable_low_first_out <= '1;
			enable_low_second_out <= '1;
			enable_high_third_out <= '0;
		end else begin
			for (int d = 0; d < NUM_DEC; d++) begin
				// only the addressed decoder gets its full enable
				if (seq != ood_pkg::OOD_IDLE && bank == d[ADDR_W-4:0]) begin
					enable_low_first_out[d] <= 1'b0;
					enable_low_second_out[d] <= 1'b0;
					enable_high_third_out[d] <= 1'b1;
				end else begin
					enable_low_first_out[d] <= 1'b1;
					enable_low_second_out[d] <= 1'b0;
					enable_high_third_out[d] <= 1'b1;
				end
			end
		end
	end

	// sampled result, held until the next sample
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			selects_n_out <= '1;
		end else if (seq == ood_pkg::OOD_SAMPLE) begin
			selects_n_out <= sel_sync;
		end
	end

	// exclusivity check against the prediction for the latched address
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			exclusive_ok_out <= 1'b0;
		end else if (seq == ood_pkg::OOD_SAMPLE) begin
			exclusive_ok_out <= (sel_sync == expect_n);
		end
	end

	// state lines to the select pins of the state decoder
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cpu_state_line_first_out <= 1'b0;
			cpu_state_line_second_out <= 1'b0;
			cpu_state_line_third_out <= 1'b0;
		end else begin
			// state line order puts first line at weight one
			cpu_state_line_first_out <= cpu_state_in[0];
			cpu_state_line_second_out <= cpu_state_in[1];
			cpu_state_line_third_out <= cpu_state_in[2];
		end
	end

	// gating pins: phase2 and sync gate, reset masks strobes
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strobe_phase2_out <= 1'b0;
			strobe_sync_n_out <= 1'b1;
			strobe_reset_n_out <= 1'b0;
		end else begin
			strobe_phase2_out <= phase2_in;
			strobe_sync_n_out <= sync_n_in;
			strobe_reset_n_out <= !sys_reset_in;
		end
	end

	// strobes gathered back, active high to the user
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_strobes_out <= '0;
			first_state_strobe_out <= 1'b0;
		end else begin
			state_strobes_out <= ~strobe_sync;
			// first state is code 010 on first, second, third lines
			first_state_strobe_out <= !strobe_sync[`OOD_ST_FIRST];
		end
	end
endmodule // ood_host

// *** verification/ood_dev.sv ***
// behavioural model of the decoder array and the state decoder
`timescale 1ns/100ps
module ood_dev (
	// pins driven by the host
	input wire logic [2:0] sel_in,
	input wire logic [2:0] en_low_a_in,
	input wire logic [2:0] en_low_b_in,
	input wire logic [2:0] en_high_in,
	input wire logic [2:0] st_in,
	input wire logic [2:0] st_en_in,
	// decoded outputs
	output logic [23:0] dec_n_out,
	output logic [7:0] st_n_out
);
	always_comb begin
		dec_n_out = '1;
		st_n_out = '1;
		for (int d = 0; d < 3; d++) begin
			if (!en_low_a_in[d] && !en_low_b_in[d] && en_high_in[d]) begin
				dec_n_out[d*8+sel_in] = 1'b0;
			end
		end
		if (!st_en_in[0] && !st_en_in[1] && st_en_in[2]) begin
			st_n_out[st_in] = 1'b0;
		end
	end
endmodule // ood_dev

// *** verification/ood_host_chk.sv ***
// concurrent checks on the decoder host ports
`timescale 1ns/100ps
module ood_host_chk #(
	parameter int NUM_DEC = 3,
	parameter int ADDR_W = 5
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// watched ports
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic [NUM_DEC*8-1:0] selects_n_out,
	input wire logic exclusive_ok_out,
	input wire logic sys_reset_in,
	input wire logic strobe_reset_n_out,
	input wire logic [NUM_DEC-1:0] enable_low_first_out,
	input wire logic [NUM_DEC-1:0] enable_low_second_out,
	input wire logic [NUM_DEC-1:0] enable_high_third_out,
	input wire logic [7:0] state_strobes_out,
	input wire logic first_state_strobe_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	logic [NUM_DEC-1:0] en;
	assign en = ~enable_low_first_out & ~enable_low_second_out & enable_high_third_out;
	a_one_decoder: assert property ($onehot0(en))
		else $error("two decoders enabled");
	a_addr_route: assert property ($rose(busy_out) |-> ##1 en == NUM_DEC'(1) << $past(addr_in[ADDR_W-1:3], 2))
		else $error("wrong decoder enabled");
	a_done_timing: assert property ($rose(busy_out) |-> busy_out[*5] ##1 (done_out && !busy_out))
		else $error("done not on time");
	a_exclusive_sel: assert property (done_out |-> exclusive_ok_out && $onehot0(~selects_n_out))
		else $error("selects not exclusive");
	a_reset_pin: assert property ($past(arst_n_in) |-> strobe_reset_n_out == !$past(sys_reset_in))
		else $error("reset not gated to enable");
	a_reset_quiet: assert property (sys_reset_in[*6] |-> state_strobes_out == 8'h00)
		else $error("strobe during reset");
	a_strobe_map: assert property ($onehot0(state_strobes_out) && first_state_strobe_out == state_strobes_out[2])
		else $error("strobe map wrong");
	c_decode: cover property (done_out && selects_n_out != '1);
	c_none: cover property (done_out && selects_n_out == '1);
	c_first: cover property (first_state_strobe_out);
endmodule // ood_host_chk
bind ood_host ood_host_chk #(.NUM_DEC(NUM_DEC), .ADDR_W(ADDR_W)) u_chk (.*);

// *** verification/ood_host_bench.sv ***
// self-checking bench for the decoder host against a behavioural decoder array
`timescale 1ns/100ps
module ood_host_bench;
	logic ref_clk_in = 0, arst_n_in = 0, req_in = 0, phase2_in = 0, sync_n_in = 1, sys_reset_in = 0;
	logic busy_out, done_out, exclusive_ok_out, first_state_strobe_out, w1, w2, w4, st_a, st_b, st_c, sp, ss, sr;
	logic [4:0] addr_in = 0;
	logic [2:0] cpu_state_in = 0, en_a, en_b, en_c;
	logic [23:0] selects_n_out, dn;
	logic [7:0] state_strobes_out, sn;
	logic [23:0] exp_q[$];
	logic [4:0] corner[4] = '{5'h00, 5'h17, 5'h18, 5'h1f};
	logic [31:0] rnd = 32'hfd95;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	ood_host u_dut (.select_bit_weight1_out(w1), .select_bit_weight2_out(w2), .select_bit_weight4_out(w4),
		.enable_low_first_out(en_a), .enable_low_second_out(en_b), .enable_high_third_out(en_c), .decoded_out_n_in(dn),
		.cpu_state_line_first_out(st_a), .cpu_state_line_second_out(st_b), .cpu_state_line_third_out(st_c),
		.strobe_phase2_out(sp), .strobe_sync_n_out(ss), .strobe_reset_n_out(sr), .state_strobe_n_in(sn), .*);
	ood_dev u_dev (.sel_in({w4, w2, w1}), .en_low_a_in(en_a), .en_low_b_in(en_b), .en_high_in(en_c),
		.st_in({st_c, st_b, st_a}), .st_en_in({sp, ~sr, ss}), .dec_n_out(dn), .st_n_out(sn));
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// requests held while busy must be ignored, so the address is scrambled then
	task automatic dec(input logic [4:0] a);
		req_in = 1;
		addr_in = a;
		exp_q.push_back(a < 24 ? ~(24'h1 << a) : 24'hffffff);
		repeat (4) begin
			@(negedge ref_clk_in);
			addr_in = ~a;
		end
		req_in = 0;
		while (busy_out === 1'b1) @(negedge ref_clk_in);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	initial begin
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	always @(negedge ref_clk_in) begin
		if (done_out === 1'b1) begin
			chk("selects", exp_q.pop_front(), selects_n_out);
			chk("exclusive", 24'h1, {23'h0, exclusive_ok_out});
		end
	end
	initial begin
		repeat (10) @(negedge ref_clk_in);
		arst_n_in = 1;
		foreach (corner[i]) dec(corner[i]);
		repeat (20) begin
			rnd = xs(rnd);
			dec(rnd[4:0]);
		end
		phase2_in = 1;
		sync_n_in = 0;
		for (int s = 0; s < 8; s++) begin
			cpu_state_in = 3'(s);
			repeat (6) @(negedge ref_clk_in);
			chk("strobes", {16'h0, 8'h1 << s}, {16'h0, state_strobes_out});
			chk("first", {23'h0, s == 2}, {23'h0, first_state_strobe_out});
		end
		phase2_in = 0;
		repeat (6) @(negedge ref_clk_in);
		chk("gated", 24'h0, {16'h0, state_strobes_out});
		phase2_in = 1;
		sys_reset_in = 1;
		repeat (6) @(negedge ref_clk_in);
		chk("reset", 24'h0, {16'h0, state_strobes_out});
		// a reset in mid-run clears the captured selects, then a fresh request must go through
		arst_n_in = 0;
		@(negedge ref_clk_in);
		chk("reset selects", 24'hffffff, selects_n_out);
		arst_n_in = 1;
		dec(5'h05);
		end_sim();
	end
endmodule // ood_host_bench
